/* rtl/bwhp_pkg.sv */
/*
  Constants for the boot-window host port controller: pin widths, window
  layout, cascade straps, state encoding and pin timing counts.
  Assumes a single 100 MHz clock feeds every user of this package.
*/
package bwhp_pkg;

  // pin widths
  localparam int ADDR_W     = 13;
  localparam int DATA_W     = 8;
  localparam int SLOT_W     = 2;

  // window layout: region bits, ignored alias bits, boot block offset
  localparam int BOOT_OFF_W = 9;
  localparam int ALIAS_W    = 2;
  localparam int REGION_W   = 2;
  localparam logic [REGION_W-1:0] REGION_BOOT_LO = 2'h0;
  localparam logic [REGION_W-1:0] REGION_BOOT_HI = 2'h3;
  localparam logic [ALIAS_W-1:0]  ALIAS_ZERO     = 2'h0;

  // cascade strap for a system with one device
  localparam logic [SLOT_W-1:0] SINGLE_SLOT = 2'h0;

  // clock
  localparam int CLK_NS = 10;

  // pin timing, figures in ns
  localparam int RESET_HOLD_NS = 1000;
  localparam int GUARD_NS      = 100;
  localparam int SETUP_NS      = 20;
  localparam int STROBE_NS     = 150;
  localparam int HOLD_NS       = 20;
  localparam int DOWNLOAD_NS   = 1000000;

  // least times round up to whole cycles
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int GUARD_CYC      = (GUARD_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC      = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC     = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC       = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int DOWNLOAD_CYC   = (DOWNLOAD_NS + CLK_NS - 1) / CLK_NS;

  // counter wide enough for the download timeout
  localparam int CNT_W = 17;
  typedef logic [CNT_W-1:0] bwhp_cnt_t;

  typedef enum logic [2:0] {
    ST_RST_HOLD,
    ST_GUARD,
    ST_WAIT_BUSY,
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } bwhp_state_t;

endpackage

/* rtl/bwhp_sync3.sv */
/*
  Three-stage input synchroniser, one lane per bit.
  Assumes inputs are asynchronous pins; the output follows only once
  the second and third stages agree, which filters single-cycle glitches.
*/
module bwhp_sync3 #(
  parameter int         WIDTH     = 1,
  parameter logic [0:0] RESET_VAL = 1'b0
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_lane
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic out_q;
      // first stage is read by the second stage only
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          s1_q  <= RESET_VAL;
          s2_q  <= RESET_VAL;
          s3_q  <= RESET_VAL;
          out_q <= RESET_VAL;
        end else begin
          s1_q <= async_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            out_q <= s3_q;
          end
        end
      end
      assign sync_out[i] = out_q;
    end
  endgenerate

endmodule

/* rtl/bwhp_host.sv */
/*
  Host-side controller for a strobe-timed flash disk memory window.
  Pulses the device reset, waits for the busy line, then runs single
  byte reads and writes over address, data and active-low strobes.
  Assumes the busy pin and data bus are asynchronous to clk_in and that
  the board resolves the open-drain busy net and the shared data bus.
*/
// How it works
// - select, read, write strobes are active low
// - no access started while busy is low
// - single device straps cascade position to 00
// - cascaded devices share all pins, busy too
module bwhp_host #(
  parameter logic [bwhp_pkg::SLOT_W-1:0] SLOT          = bwhp_pkg::SINGLE_SLOT,
  parameter int                          DOWNLOAD_CYC  = bwhp_pkg::DOWNLOAD_CYC
) (
  input  wire logic                          clk_in,
  input  wire logic                          reset_in,
  // user side
  input  wire logic                          cmd_valid_in,
  input  wire logic                          cmd_write_in,
  input  wire logic                          cmd_boot_in,
  input  wire logic [bwhp_pkg::ADDR_W-1:0]   cmd_addr_in,
  input  wire logic [bwhp_pkg::DATA_W-1:0]   cmd_wdata_in,
  input  wire logic                          restart_in,
  output logic                               cmd_ready_out,
  output logic [bwhp_pkg::DATA_W-1:0]        rdata_out,
  output logic                               rdata_valid_out,
  output logic                               init_done_out,
  output logic                               init_timeout_out,
  // device pins
  output logic [bwhp_pkg::ADDR_W-1:0]        dev_addr_out,
  input  wire logic [bwhp_pkg::DATA_W-1:0]   dev_data_in,
  output logic [bwhp_pkg::DATA_W-1:0]        dev_data_out,
  output logic                               dev_data_oe_out,
  output logic                               dev_ce_n_out,
  output logic                               dev_oe_n_out,
  output logic                               dev_we_n_out,
  output logic                               dev_reset_n_out,
  input  wire logic                          dev_busy_n_in,
  output logic [bwhp_pkg::SLOT_W-1:0]        cascade_slot_out
);

  bwhp_pkg::bwhp_state_t           state_q;
  bwhp_pkg::bwhp_state_t           state_d;
  bwhp_pkg::bwhp_cnt_t             cnt_q;
  bwhp_pkg::bwhp_cnt_t             cnt_init;
  logic                            cnt_zero;
  logic                            cnt_load;
  logic                            busy_hi;
  logic [bwhp_pkg::DATA_W-1:0]     data_sync;
  logic [bwhp_pkg::ADDR_W-1:0]     addr_q;
  logic [bwhp_pkg::ADDR_W-1:0]     boot_addr;
  logic [bwhp_pkg::ADDR_W-1:0]     addr_pick;
  logic [bwhp_pkg::DATA_W-1:0]     wdata_q;
  logic                            write_q;
  logic [bwhp_pkg::DATA_W-1:0]     rdata_q;
  logic                            rdata_valid_q;
  logic                            done_q;
  logic                            timeout_q;
  logic                            take_cmd;
  logic                            read_done;

  // the busy net is shared by every cascaded device, so it reads as a wired-AND
  bwhp_sync3 #(
    .WIDTH     (1),
    .RESET_VAL (1'b0)
  ) u_busy_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in (dev_busy_n_in),
    .sync_out (busy_hi)
  );

  // read data crosses in too; the strobe is long enough to cover latency
  bwhp_sync3 #(
    .WIDTH     (bwhp_pkg::DATA_W),
    .RESET_VAL (1'b0)
  ) u_data_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in (dev_data_in),
    .sync_out (data_sync)
  );

  // boot reads go to the lowest region with alias bits cleared
  assign boot_addr = {bwhp_pkg::REGION_BOOT_LO, bwhp_pkg::ALIAS_ZERO,
                      cmd_addr_in[bwhp_pkg::BOOT_OFF_W-1:0]};
  assign addr_pick = cmd_boot_in ? boot_addr : cmd_addr_in;

  // handshake and decode
  assign cnt_zero  = (cnt_q == '0);
  assign cnt_load  = (state_d != state_q);
  // ready only while the device reports itself idle
  assign cmd_ready_out = (state_q == bwhp_pkg::ST_IDLE) && busy_hi && !restart_in;
  assign take_cmd  = cmd_valid_in && cmd_ready_out;
  assign read_done = (state_q == bwhp_pkg::ST_STROBE) && cnt_zero && !write_q;

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      bwhp_pkg::ST_RST_HOLD: begin
        if (cnt_zero) state_d = bwhp_pkg::ST_GUARD;
      end
      bwhp_pkg::ST_GUARD: begin
        if (cnt_zero) state_d = bwhp_pkg::ST_WAIT_BUSY;
      end
      bwhp_pkg::ST_WAIT_BUSY: begin
        if (busy_hi || cnt_zero) state_d = bwhp_pkg::ST_IDLE;
      end
      bwhp_pkg::ST_IDLE: begin
        if (restart_in) state_d = bwhp_pkg::ST_RST_HOLD;
        else if (take_cmd) state_d = bwhp_pkg::ST_SETUP;
      end
      bwhp_pkg::ST_SETUP: begin
        if (cnt_zero) state_d = bwhp_pkg::ST_STROBE;
      end
      bwhp_pkg::ST_STROBE: begin
        if (cnt_zero) state_d = bwhp_pkg::ST_HOLD;
      end
      bwhp_pkg::ST_HOLD: begin
        if (cnt_zero) state_d = bwhp_pkg::ST_IDLE;
      end
      default: begin
        state_d = bwhp_pkg::ST_RST_HOLD;
      end
    endcase
  end

  // dwell time of the state being entered, less one
  always_comb begin
    cnt_init = '0;
    case (state_d)
      bwhp_pkg::ST_RST_HOLD:  cnt_init = bwhp_pkg::bwhp_cnt_t'(bwhp_pkg::RESET_HOLD_CYC - 1);
      bwhp_pkg::ST_GUARD:     cnt_init = bwhp_pkg::bwhp_cnt_t'(bwhp_pkg::GUARD_CYC - 1);
      bwhp_pkg::ST_WAIT_BUSY: cnt_init = bwhp_pkg::bwhp_cnt_t'(DOWNLOAD_CYC - 1);
      bwhp_pkg::ST_SETUP:     cnt_init = bwhp_pkg::bwhp_cnt_t'(bwhp_pkg::SETUP_CYC - 1);
      bwhp_pkg::ST_STROBE:    cnt_init = bwhp_pkg::bwhp_cnt_t'(bwhp_pkg::STROBE_CYC - 1);
      bwhp_pkg::ST_HOLD:      cnt_init = bwhp_pkg::bwhp_cnt_t'(bwhp_pkg::HOLD_CYC - 1);
      default:                cnt_init = '0;
    endcase
  end

  // state and dwell counter; reset starts a fresh device reset pulse
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q <= bwhp_pkg::ST_RST_HOLD;
      cnt_q   <= bwhp_pkg::bwhp_cnt_t'(bwhp_pkg::RESET_HOLD_CYC - 1);
    end else begin
      state_q <= state_d;
      if (cnt_load) cnt_q <= cnt_init;
      else if (!cnt_zero) cnt_q <= cnt_q - 1'b1;
    end
  end

  // command capture, held stable across setup, strobe and hold
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      addr_q  <= '0;
      wdata_q <= '0;
      write_q <= 1'b0;
    end else if (take_cmd) begin
      addr_q  <= addr_pick;
      wdata_q <= cmd_wdata_in;
      write_q <= cmd_write_in;
    end
  end

  // read data sampled at the last strobe cycle, when it is settled
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_q       <= '0;
      rdata_valid_q <= 1'b0;
    end else begin
      rdata_valid_q <= read_done;
      if (read_done) rdata_q <= data_sync;
    end
  end

  // init status: done when busy released, timeout if download overran
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      done_q    <= 1'b0;
      timeout_q <= 1'b0;
    end else if (state_q == bwhp_pkg::ST_RST_HOLD) begin
      done_q    <= 1'b0;
      timeout_q <= 1'b0;
    end else if (state_q == bwhp_pkg::ST_WAIT_BUSY) begin
      done_q    <= busy_hi;
      timeout_q <= !busy_hi && cnt_zero;
    end
  end

  // pin drive; strobes are active low and exclusive
  assign dev_reset_n_out  = (state_q != bwhp_pkg::ST_RST_HOLD);
  assign dev_ce_n_out     = !((state_q == bwhp_pkg::ST_SETUP) ||
                              (state_q == bwhp_pkg::ST_STROBE));
  assign dev_oe_n_out     = !((state_q == bwhp_pkg::ST_STROBE) && !write_q);
  assign dev_we_n_out     = !((state_q == bwhp_pkg::ST_STROBE) && write_q);
  // data driven over the whole write cycle so it is stable at we rise
  assign dev_data_oe_out  = write_q && ((state_q == bwhp_pkg::ST_SETUP) ||
                                        (state_q == bwhp_pkg::ST_STROBE) ||
                                        (state_q == bwhp_pkg::ST_HOLD));
  assign dev_data_out     = wdata_q;
  assign dev_addr_out     = addr_q;
  assign cascade_slot_out = SLOT;
  assign rdata_out        = rdata_q;
  assign rdata_valid_out  = rdata_valid_q;
  assign init_done_out    = done_q;
  assign init_timeout_out = timeout_q;

  property p_no_dual_strobe;
    @(posedge clk_in) disable iff (reset_in)
      !(!dev_oe_n_out && !dev_we_n_out);
  endproperty
  a_no_dual_strobe: assert property (p_no_dual_strobe)
    else $error("read and write strobes low together");

  property p_strobe_needs_ce;
    @(posedge clk_in) disable iff (reset_in)
      (!dev_oe_n_out || !dev_we_n_out) |-> !dev_ce_n_out;
  endproperty
  a_strobe_needs_ce: assert property (p_strobe_needs_ce)
    else $error("strobe without chip select");

  property p_read_width;
    @(posedge clk_in) disable iff (reset_in)
      $fell(dev_oe_n_out) |-> !dev_oe_n_out [*8];
  endproperty
  a_read_width: assert property (p_read_width)
    else $error("read strobe too short");

  property p_write_data;
    @(posedge clk_in) disable iff (reset_in)
      !dev_we_n_out |-> dev_data_oe_out ##1 dev_data_oe_out;
  endproperty
  a_write_data: assert property (p_write_data)
    else $error("write strobe without data held");

  property p_start_when_idle;
    @(posedge clk_in) disable iff (reset_in)
      take_cmd |-> busy_hi ##1 (!dev_ce_n_out && dev_oe_n_out && dev_we_n_out);
  endproperty
  a_start_when_idle: assert property (p_start_when_idle)
    else $error("access started while device busy");

  property p_busy_blocks;
    @(posedge clk_in) disable iff (reset_in)
      !busy_hi |-> !cmd_ready_out;
  endproperty
  a_busy_blocks: assert property (p_busy_blocks)
    else $error("ready offered while device busy");

  property p_after_reset_wait;
    @(posedge clk_in) disable iff (reset_in)
      $rose(dev_reset_n_out) |-> (!cmd_ready_out && dev_ce_n_out) [*8];
  endproperty
  a_after_reset_wait: assert property (p_after_reset_wait)
    else $error("access offered right after device reset");

  property p_slot_fixed;
    @(posedge clk_in) disable iff (reset_in)
      1'b1 |=> $stable(cascade_slot_out) && (cascade_slot_out == SLOT);
  endproperty
  a_slot_fixed: assert property (p_slot_fixed)
    else $error("cascade strap changed");

endmodule

/* testbench/bwhp_dev_model.sv */
/*
  Behavioural flash-disk window device for the host port bench.
  Assumes the bench resolves the busy and data nets; timing is strobe driven.
*/
module bwhp_dev_model #(
  parameter logic [1:0] MY_SLOT = 2'h0,
  parameter int         BUSY_NS = 600
) (
  input  wire logic [12:0] addr_in,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe_out,
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic        reset_n_in,
  input  wire logic [1:0]  slot_in,
  input  wire logic        page0_bad_in,
  output logic             busy_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:8191];
  logic       busy_q = 1'b1;
  // both boot regions fold onto one 512-byte block, middle kept apart
  wire        boot_hit = (addr_in[12:11] == 2'h0) || (addr_in[12:11] == 2'h3);
  wire [12:0] idx      = boot_hit ? {4'h0, addr_in[8:0]} : addr_in;
  wire        sel      = !ce_n_in && (slot_in == MY_SLOT) && !busy_q;
  wire        strobe_w = sel && !we_n_in;
  // reads come straight from the array so code can run in place
  assign data_oe_out = sel && !oe_n_in && we_n_in;
  assign data_out    = mem[idx];
  assign busy_oe_out = busy_q;
  // write lands as the strobe ends, address and data still held
  always @(negedge strobe_w) mem[idx] = data_in;
  // busy from reset entry until the boot image is in place
  always @(negedge reset_n_in) busy_q = 1'b1;
  always @(posedge reset_n_in) begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = page0_bad_in ? 8'(i) ^ 8'h3C : 8'(i) ^ 8'hA5;
    end
    #(BUSY_NS);
    if (reset_n_in) busy_q = 1'b0;
  end
endmodule

/* testbench/bwhp_host_tb_top.sv */
/*
  Self-checking bench for the boot-window host port controller.
  Assumes the device model beside it; busy net has a pull-up.
*/
module bwhp_host_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_in = 0, reset_in = 1, cmd_valid_in = 0, cmd_write_in = 0;
  logic        cmd_boot_in = 0, restart_in = 0, page0_bad = 0, busy_stuck = 0;
  logic [12:0] cmd_addr_in = '0, a;
  logic [7:0]  cmd_wdata_in = '0, got, last_bus = '0, rdata_out, dev_data_out, dd_out;
  logic        cmd_ready_out, rdata_valid_out, init_done_out, init_timeout_out;
  logic        dev_data_oe_out, dev_ce_n_out, dev_oe_n_out, dev_we_n_out;
  logic        dev_reset_n_out, dd_oe, busy_oe;
  logic [12:0] dev_addr_out;
  logic [1:0]  cascade_slot_out;
  logic [31:0] seed = 32'h9A6D;
  logic [7:0]  ref_mem [0:8191];
  logic [12:0] mid_q [$];
  logic [12:0] alias_a [2] = '{13'h0205, 13'h1805};
  int          error_cnt = 0, comparisons = 0, cycles = 0;
  // released data bus shows a changing pattern, busy net pulled up
  wire [7:0]   data_bus = dev_data_oe_out ? dev_data_out : dd_oe ? dd_out : ~last_bus;
  // busy_stuck stands in for a second device that never finishes its download
  wire         busy_net = !busy_oe && !busy_stuck;

  bwhp_host #(.DOWNLOAD_CYC(200)) uut (.clk_in(clk_in), .reset_in(reset_in),
    .cmd_valid_in(cmd_valid_in), .cmd_write_in(cmd_write_in), .cmd_boot_in(cmd_boot_in),
    .cmd_addr_in(cmd_addr_in), .cmd_wdata_in(cmd_wdata_in), .restart_in(restart_in),
    .cmd_ready_out(cmd_ready_out), .rdata_out(rdata_out), .rdata_valid_out(rdata_valid_out),
    .init_done_out(init_done_out), .init_timeout_out(init_timeout_out),
    .dev_addr_out(dev_addr_out), .dev_data_in(data_bus), .dev_data_out(dev_data_out),
    .dev_data_oe_out(dev_data_oe_out), .dev_ce_n_out(dev_ce_n_out),
    .dev_oe_n_out(dev_oe_n_out), .dev_we_n_out(dev_we_n_out),
    .dev_reset_n_out(dev_reset_n_out), .dev_busy_n_in(busy_net),
    .cascade_slot_out(cascade_slot_out));
  bwhp_dev_model dev (.addr_in(dev_addr_out), .data_in(data_bus), .data_out(dd_out),
    .data_oe_out(dd_oe), .ce_n_in(dev_ce_n_out), .oe_n_in(dev_oe_n_out),
    .we_n_in(dev_we_n_out), .reset_n_in(dev_reset_n_out), .slot_in(cascade_slot_out),
    .page0_bad_in(page0_bad), .busy_oe_out(busy_oe));

  initial forever #5 clk_in = ~clk_in;
  always @(posedge clk_in) last_bus <= data_bus;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [12:0] ref_idx(input logic [12:0] x);
    return (x[12:11] == 2'h0 || x[12:11] == 2'h3) ? {4'h0, x[8:0]} : x;
  endfunction
  task automatic fill_boot(input logic bad);
    for (int i = 0; i < 512; i++) ref_mem[i] = bad ? 8'(i) ^ 8'h3C : 8'(i) ^ 8'hA5;
  endtask
  task automatic check(input logic [7:0] g, input logic [7:0] e, input string what);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one command: hold valid until ready seen, then wait for the read answer
  task automatic do_cmd(input logic wr, input logic bt, input logic [12:0] ad,
                        input logic [7:0] wd);
    int n;
    n = 0;
    @(negedge clk_in);
    cmd_valid_in = 1'b1;
    cmd_write_in = wr;
    cmd_boot_in = bt;
    cmd_addr_in = ad;
    cmd_wdata_in = wd;
    while (cmd_ready_out !== 1'b1 && n < 300) begin
      @(negedge clk_in);
      n++;
    end
    check({7'h0, cmd_ready_out}, 8'h1, "command taken");
    @(negedge clk_in);
    cmd_valid_in = 1'b0;
    n = 0;
    while (!wr && rdata_valid_out !== 1'b1 && n < 40) begin
      @(negedge clk_in);
      n++;
    end
    if (!wr) check({7'h0, rdata_valid_out}, 8'h1, "read answer");
    if (wr) ref_mem[ref_idx(ad)] = wd;
    got = rdata_out;
  endtask
  task automatic wait_ready();
    for (int n = 0; n < 2000 && cmd_ready_out !== 1'b1; n++) @(negedge clk_in);
    check({6'h0, init_done_out, init_timeout_out}, 8'h2, "init flags");
  endtask
  // restart is only decoded in idle, so wait for it before the pulse
  task automatic restart_dev();
    for (int n = 0; n < 100 && cmd_ready_out !== 1'b1; n++) @(negedge clk_in);
    restart_in = 1'b1;
    @(negedge clk_in);
    restart_in = 1'b0;
    repeat (3) @(negedge clk_in);
    check({6'h0, dev_reset_n_out, busy_net}, 8'h0, "reset and busy low");
  endtask

  // pin watch: no strobe while busy, never read and write at once
  always @(negedge clk_in) begin
    cycles++;
    if (dev_ce_n_out === 1'b0 && busy_net !== 1'b1) check(8'h1, 8'h0, "access while busy");
    if (dev_oe_n_out === 1'b0 && dev_we_n_out === 1'b0) check(8'h1, 8'h0, "oe and we");
    if (cycles > 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  initial begin
    fill_boot(1'b0);
    repeat (10) @(negedge clk_in);
    reset_in = 1'b0;
    wait_ready();
    check({6'h0, cascade_slot_out}, 8'h0, "single strap");
    $display("test init done");
    // random boot reads across both regions and their aliases
    for (int k = 0; k < 12; k++) begin
      seed = lfsr(seed);
      a = {seed[0] ? 2'h3 : 2'h0, seed[11:1]};
      do_cmd(1'b0, seed[12], a, 8'h00);
      check(got, ref_mem[ref_idx(a)], "boot read");
    end
    $display("test boot reads done");
    // write one alias, read it back through the others
    seed = lfsr(seed);
    do_cmd(1'b1, 1'b0, 13'h1A05, seed[7:0]);
    foreach (alias_a[j]) begin
      do_cmd(1'b0, 1'b0, alias_a[j], 8'h00);
      check(got, seed[7:0], "alias other");
    end
    do_cmd(1'b0, 1'b0, 13'h0005, 8'h00);
    check(got, seed[7:0], "alias lo");
    do_cmd(1'b0, 1'b0, 13'h1E05, 8'h00);
    check(got, seed[7:0], "alias hi");
    $display("test alias done");
    // back-to-back middle writes, then read all back
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      a = 13'h0800 + {1'b0, seed[11:0]};
      mid_q.push_back(a);
      do_cmd(1'b1, 1'b0, a, seed[19:12]);
    end
    foreach (mid_q[k]) begin
      do_cmd(1'b0, 1'b0, mid_q[k], 8'h00);
      check(got, ref_mem[mid_q[k]], "middle read");
    end
    $display("test middle writes done");
    // busy never released: timeout flag set, ready still withheld
    restart_dev();
    busy_stuck = 1'b1;
    for (int n = 0; n < 400 && init_timeout_out !== 1'b1; n++) @(negedge clk_in);
    check({6'h0, init_done_out, init_timeout_out}, 8'h1, "timeout flags");
    check({7'h0, cmd_ready_out}, 8'h0, "ready while busy");
    busy_stuck = 1'b0;
    $display("test timeout done");
    // restart with a bad first page: fallback image expected
    page0_bad = 1'b1;
    restart_dev();
    fill_boot(1'b1);
    wait_ready();
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      do_cmd(1'b0, 1'b1, seed[12:0], 8'h00);
      check(got, ref_mem[seed[8:0]], "fallback image");
    end
    $display("test restart done");
    print_verdict();
  end
endmodule
